// ### rtl/cosc_pkg.sv
package cosc_pkg;
  // Structure
  localparam int CHANNELS = 2;
  localparam int DATA_W = 16;
  localparam int CODE_W = 12;
  localparam int CTRL_W = 8;
  localparam int IDX_W = 6;
  localparam int ADDR_W = 7;
  localparam int CH_SEL_BIT = 6;
  localparam int IRQ_W = 4;
  localparam int TICK_W = 24;
  localparam int WDT_W = 12;

  // Register indices, per channel unless noted
  localparam logic [IDX_W-1:0] IDX_PROC = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DIAG = 6'h06;
  localparam logic [IDX_W-1:0] IDX_MOFF = 6'h13;
  localparam logic [IDX_W-1:0] IDX_MGAIN = 6'h14;
  localparam logic [IDX_W-1:0] IDX_MODE = 6'h20;
  localparam logic [IDX_W-1:0] IDX_UOFF = 6'h21;
  localparam logic [IDX_W-1:0] IDX_UGAIN = 6'h22;
  localparam logic [IDX_W-1:0] IDX_FALLBACK = 6'h23;
  // Shared, reached through channel 0 only
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h3E;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h3F;

  // Field positions
  localparam int MODE_MAKER_BIT = 0;
  localparam int MODE_USER_BIT = 1;
  localparam int MODE_FALLBACK_BIT = 2;
  localparam int CTRL_REG_BIT = 7;
  localparam int CTRL_WNR_BIT = 6;
  localparam int DIAG_TIMEOUT_BIT = 0;
  localparam int DIAG_RUN_BIT = 1;
  localparam int IRQ_WDT_BASE = 0;
  localparam int IRQ_WR_BASE = 2;
  localparam int GAIN_FRAC = 8;
  localparam int CODE_TOP = DATA_W - 2;

  // Reset values, then zero, saturation and code-floor constants
  localparam logic [DATA_W-1:0] RST_GAIN = 16'h0100;
  localparam logic [DATA_W-1:0] RST_OFFSET = 16'h0000;
  localparam logic [DATA_W-1:0] RST_MODE = 16'h0000;
  localparam logic [DATA_W-1:0] RST_FALLBACK = 16'h0000;
  localparam logic [DATA_W-1:0] PV_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] SAT_POS = 16'h7FFF;
  localparam logic [DATA_W-1:0] SAT_NEG = 16'h8000;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_TIME_MS = 100;
  localparam int TICK_MS = 1;
  localparam int WDT_TICKS = WDT_TIME_MS / TICK_MS;
endpackage

// ### rtl/cosc_scale.sv
`timescale 1ns/1ps
module cosc_scale
  import cosc_pkg::*;
(
  // Straight line y = offset + gain * x, gain with GAIN_FRAC fraction bits
  input wire logic [DATA_W-1:0] x_in,
  input wire logic [DATA_W-1:0] offset_in,
  input wire logic [DATA_W-1:0] gain_in,
  output logic [DATA_W-1:0] y_out
);
  logic signed [2*DATA_W-1:0] prod;
  logic signed [2*DATA_W-1:0] prod_sh;
  logic signed [2*DATA_W:0] sum;

  always_comb begin
    prod = $signed(gain_in) * $signed(x_in);
    prod_sh = prod >>> GAIN_FRAC;
    sum = $signed({{(DATA_W+1){offset_in[DATA_W-1]}}, offset_in}) +
          $signed({prod_sh[2*DATA_W-1], prod_sh});
    // Saturate so a large gain never wraps the sign
    if ((sum[2*DATA_W:DATA_W-1] == '0) || (sum[2*DATA_W:DATA_W-1] == '1)) begin
      y_out = sum[DATA_W-1:0];
    end else if (sum[2*DATA_W]) begin
      y_out = SAT_NEG;
    end else begin
      y_out = SAT_POS;
    end
  end
endmodule

// ### rtl/cosc_top.sv
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module cosc_top
  import cosc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int WDT_TICKS_P = WDT_TICKS
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // Process data from the coupler
  input wire logic [CHANNELS-1:0] pd_valid_in,
  input wire logic [CHANNELS-1:0] pd_ctrl_en_in,
  input wire logic [CHANNELS-1:0][CTRL_W-1:0] pd_ctrl_in,
  input wire logic [CHANNELS-1:0][DATA_W-1:0] pd_data_in,
  // Returned status and register data
  output logic [CHANNELS-1:0][CTRL_W-1:0] pd_status_out,
  output logic [CHANNELS-1:0][DATA_W-1:0] pd_rdata_out,
  // Converter and indicators
  output logic [CHANNELS-1:0][CODE_W-1:0] dac_code_out,
  output logic [CHANNELS-1:0] channel_run_indicator_out,
  output logic irq_out
);
  typedef struct packed {
    logic [CHANNELS-1:0][DATA_W-1:0] pv;
    logic [CHANNELS-1:0][DATA_W-1:0] mode;
    logic [CHANNELS-1:0][DATA_W-1:0] moff;
    logic [CHANNELS-1:0][DATA_W-1:0] mgain;
    logic [CHANNELS-1:0][DATA_W-1:0] uoff;
    logic [CHANNELS-1:0][DATA_W-1:0] ugain;
    logic [CHANNELS-1:0][DATA_W-1:0] fallback;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [CHANNELS-1:0][WDT_W-1:0] wdt;
    logic [CHANNELS-1:0] timeout;
    logic [CHANNELS-1:0] run;
    logic [CHANNELS-1:0][CODE_W-1:0] code;
    logic [CHANNELS-1:0][CTRL_W-1:0] status;
    logic [CHANNELS-1:0][DATA_W-1:0] pd_rdata;
    logic [DATA_W-1:0] rdata;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic irq;
  } cosc_state_s;

  cosc_state_s q;
  cosc_state_s n;

  logic [CHANNELS-1:0][DATA_W-1:0] maker_y;
  logic [CHANNELS-1:0][DATA_W-1:0] user_x;
  logic [CHANNELS-1:0][DATA_W-1:0] user_y;
  logic [CHANNELS-1:0][DATA_W-1:0] scaled;

  function automatic logic [DATA_W-1:0] read_reg(input cosc_state_s s, input logic ch,
                                                input logic [IDX_W-1:0] idx);
    logic [DATA_W-1:0] r;
    r = '0;
    case (idx)
      IDX_PROC: r = s.pv[ch];
      IDX_DIAG: begin
        r[DIAG_TIMEOUT_BIT] = s.timeout[ch];
        r[DIAG_RUN_BIT] = s.run[ch];
      end
      IDX_MOFF: r = s.moff[ch];
      IDX_MGAIN: r = s.mgain[ch];
      IDX_MODE: r = s.mode[ch];
      IDX_UOFF: r = s.uoff[ch];
      IDX_UGAIN: r = s.ugain[ch];
      IDX_FALLBACK: r = s.fallback[ch];
      IDX_IRQ_STAT: r[IRQ_W-1:0] = ch ? '0 : s.irq_stat;
      IDX_IRQ_MASK: r[IRQ_W-1:0] = ch ? '0 : s.irq_mask;
      default: r = '0;
    endcase
    return r;
  endfunction

  // Unlisted indices swallow writes silently
  function automatic cosc_state_s write_reg(input cosc_state_s s, input logic ch,
                                            input logic [IDX_W-1:0] idx,
                                            input logic [DATA_W-1:0] d);
    cosc_state_s r;
    r = s;
    case (idx)
      IDX_MOFF: r.moff[ch] = d;
      IDX_MGAIN: r.mgain[ch] = d;
      IDX_MODE: r.mode[ch] = d;
      IDX_UOFF: r.uoff[ch] = d;
      IDX_UGAIN: r.ugain[ch] = d;
      IDX_FALLBACK: r.fallback[ch] = d;
      IDX_IRQ_STAT: begin
        if (!ch) begin
          r.irq_stat = s.irq_stat & ~d[IRQ_W-1:0];
        end
      end
      IDX_IRQ_MASK: begin
        if (!ch) begin
          r.irq_mask = d[IRQ_W-1:0];
        end
      end
      default: r = s;
    endcase
    return r;
  endfunction

  // Negative results hold the floor, top of range maps to the top code
  function automatic logic [CODE_W-1:0] to_code(input logic [DATA_W-1:0] v);
    if (v[DATA_W-1]) begin
      return CODE_MIN;
    end
    return v[CODE_TOP -: CODE_W];
  endfunction

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : g_ch
      cosc_scale u_maker (
        .x_in(q.pv[g]),
        .offset_in(q.moff[g]),
        .gain_in(q.mgain[g]),
        .y_out(maker_y[g])
      );
      assign user_x[g] = q.mode[g][MODE_MAKER_BIT] ? maker_y[g] : q.pv[g];
      cosc_scale u_user (
        .x_in(user_x[g]),
        .offset_in(q.uoff[g]),
        .gain_in(q.ugain[g]),
        .y_out(user_y[g])
      );
      assign scaled[g] = q.mode[g][MODE_USER_BIT] ? user_y[g] : user_x[g];
    end
  endgenerate

  always_comb begin
    n = q;
    n.tick = 1'b0;
    // One-millisecond enable shared by both watchdogs
    if (q.tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = q.tick_cnt + 1'b1;
    end
    n.rdata = '0;
    if (reg_rd_in) begin
      n.rdata = read_reg(q, reg_addr_in[CH_SEL_BIT], reg_addr_in[IDX_W-1:0]);
    end
    if (reg_wr_in) begin
      n = write_reg(n, reg_addr_in[CH_SEL_BIT], reg_addr_in[IDX_W-1:0], reg_wdata_in);
    end
    for (int c = 0; c < CHANNELS; c++) begin
      // Coupler traffic comes after the port write so it wins a collision
      if (pd_valid_in[c]) begin
        if (pd_ctrl_en_in[c] && pd_ctrl_in[c][CTRL_REG_BIT]) begin
          if (pd_ctrl_in[c][CTRL_WNR_BIT]) begin
            n = write_reg(n, c[0], pd_ctrl_in[c][IDX_W-1:0], pd_data_in[c]);
            n.irq_stat[IRQ_WR_BASE + c] = 1'b1;
          end else begin
            n.pd_rdata[c] = read_reg(q, c[0], pd_ctrl_in[c][IDX_W-1:0]);
          end
          n.status[c] = pd_ctrl_in[c];
        end else begin
          n.pv[c] = pd_data_in[c];
          n.status[c] = '0;
        end
        n.wdt[c] = '0;
        n.timeout[c] = 1'b0;
      end else if (q.tick && !q.timeout[c]) begin
        if (q.wdt[c] == WDT_W'(WDT_TICKS_P)) begin
          n.timeout[c] = 1'b1;
          n.irq_stat[IRQ_WDT_BASE + c] = 1'b1;
        end else begin
          n.wdt[c] = q.wdt[c] + 1'b1;
        end
      end
      if (q.timeout[c]) begin
        n.code[c] = to_code(q.mode[c][MODE_FALLBACK_BIT] ? q.fallback[c] : PV_ZERO);
      end else begin
        n.code[c] = to_code(scaled[c]);
      end
    end
    n.run = ~n.timeout;
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.mode <= {CHANNELS{RST_MODE}};
      q.moff <= {CHANNELS{RST_OFFSET}};
      q.mgain <= {CHANNELS{RST_GAIN}};
      q.uoff <= {CHANNELS{RST_OFFSET}};
      q.ugain <= {CHANNELS{RST_GAIN}};
      q.fallback <= {CHANNELS{RST_FALLBACK}};
      q.run <= '1;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_out = q.rdata;
  assign pd_status_out = q.status;
  assign pd_rdata_out = q.pd_rdata;
  assign dac_code_out = q.code;
  assign channel_run_indicator_out = q.run;
  assign irq_out = q.irq;

  // Helpers for the checks on channel 0
  logic [CODE_W-1:0] pv0_top;
  logic [CODE_W-1:0] fb0_top;
  logic plain0;
  logic regwr_mode0;
  assign pv0_top = q.pv[0][CODE_TOP -: CODE_W];
  assign fb0_top = q.fallback[0][CODE_TOP -: CODE_W];
  assign plain0 = !q.timeout[0] && !q.mode[0][MODE_MAKER_BIT] && !q.mode[0][MODE_USER_BIT];
  assign regwr_mode0 = pd_valid_in[0] && pd_ctrl_en_in[0] && pd_ctrl_in[0][CTRL_REG_BIT] &&
                       pd_ctrl_in[0][CTRL_WNR_BIT] && (pd_ctrl_in[0][IDX_W-1:0] == IDX_MODE);

  property p_plain_code;
    @(posedge clock_in) disable iff (!rst_b_in)
    (plain0 && !q.pv[0][DATA_W-1]) |=> (dac_code_out[0] == $past(pv0_top));
  endproperty
  a_plain_code: assert property (p_plain_code) else $error("plain code mismatch");

  property p_negative_clamp;
    @(posedge clock_in) disable iff (!rst_b_in)
    (plain0 && q.pv[0][DATA_W-1]) |=> (dac_code_out[0] == CODE_MIN);
  endproperty
  a_negative_clamp: assert property (p_negative_clamp) else $error("negative not clamped");

  property p_run_tracks;
    @(posedge clock_in) disable iff (!rst_b_in)
    !channel_run_indicator_out[0] |-> (q.wdt[0] == WDT_W'(WDT_TICKS_P));
  endproperty
  a_run_tracks: assert property (p_run_tracks) else $error("run indicator wrong");

  property p_wdt_restart;
    @(posedge clock_in) disable iff (!rst_b_in)
    pd_valid_in[0] |=> (!q.timeout[0] && (q.wdt[0] == '0));
  endproperty
  a_wdt_restart: assert property (p_wdt_restart) else $error("watchdog not restarted");

  property p_timeout_on_tick;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(q.timeout[0]) |-> ($past(q.tick) && !$past(pd_valid_in[0]));
  endproperty
  a_timeout_on_tick: assert property (p_timeout_on_tick) else $error("timeout off tick");

  property p_fallback_code;
    @(posedge clock_in) disable iff (!rst_b_in)
    (q.timeout[0] && q.mode[0][MODE_FALLBACK_BIT] && !q.fallback[0][DATA_W-1])
      |=> (dac_code_out[0] == $past(fb0_top));
  endproperty
  a_fallback_code: assert property (p_fallback_code) else $error("fallback not driven");

  property p_status_echo;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pd_valid_in[0] && pd_ctrl_en_in[0] && pd_ctrl_in[0][CTRL_REG_BIT])
      |=> (pd_status_out[0] == $past(pd_ctrl_in[0]));
  endproperty
  a_status_echo: assert property (p_status_echo) else $error("status not echoed");

  property p_mode_write;
    @(posedge clock_in) disable iff (!rst_b_in)
    regwr_mode0 |=> ##1 (q.mode[0] == $past(pd_data_in[0], 2));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_pv_capture;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pd_valid_in[0] && !(pd_ctrl_en_in[0] && pd_ctrl_in[0][CTRL_REG_BIT]))
      |=> ((q.pv[0] == $past(pd_data_in[0])) && (pd_status_out[0] == '0));
  endproperty
  a_pv_capture: assert property (p_pv_capture) else $error("process value not taken");

  property p_fallback_zero;
    @(posedge clock_in) disable iff (!rst_b_in)
    (q.timeout[0] && !q.mode[0][MODE_FALLBACK_BIT]) |=> (dac_code_out[0] == CODE_MIN);
  endproperty
  a_fallback_zero: assert property (p_fallback_zero) else $error("timeout floor wrong");

  property p_write_irq;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pd_valid_in[0] && pd_ctrl_en_in[0] && pd_ctrl_in[0][CTRL_REG_BIT] &&
     pd_ctrl_in[0][CTRL_WNR_BIT]) |=> q.irq_stat[IRQ_WR_BASE];
  endproperty
  a_write_irq: assert property (p_write_irq) else $error("write event not flagged");

  property p_wdt_full;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(q.timeout[0]) |-> ($past(q.wdt[0]) == WDT_W'(WDT_TICKS_P));
  endproperty
  a_wdt_full: assert property (p_wdt_full) else $error("timeout before full count");

  property p_wdt_irq;
    @(posedge clock_in) disable iff (!rst_b_in)
    $rose(q.timeout[0]) |-> q.irq_stat[IRQ_WDT_BASE];
  endproperty
  a_wdt_irq: assert property (p_wdt_irq) else $error("overflow not flagged");

  property p_plain_code1;
    @(posedge clock_in) disable iff (!rst_b_in)
    (!q.timeout[1] && !q.mode[1][MODE_MAKER_BIT] && !q.mode[1][MODE_USER_BIT] &&
     !q.pv[1][DATA_W-1]) |=> (dac_code_out[1] == $past(q.pv[1][CODE_TOP -: CODE_W]));
  endproperty
  a_plain_code1: assert property (p_plain_code1) else $error("plain code mismatch on 1");

  property p_read_access1;
    @(posedge clock_in) disable iff (!rst_b_in)
    (pd_valid_in[1] && pd_ctrl_en_in[1] && pd_ctrl_in[1][CTRL_REG_BIT] &&
     !pd_ctrl_in[1][CTRL_WNR_BIT] && (pd_ctrl_in[1][IDX_W-1:0] == IDX_FALLBACK))
      |=> (pd_rdata_out[1] == $past(q.fallback[1]));
  endproperty
  a_read_access1: assert property (p_read_access1) else $error("register read wrong");

  property p_run_off1;
    @(posedge clock_in) disable iff (!rst_b_in)
    !channel_run_indicator_out[1] |-> (q.wdt[1] == WDT_W'(WDT_TICKS_P));
  endproperty
  a_run_off1: assert property (p_run_off1) else $error("run indicator off early");

  property p_saturate;
    @(posedge clock_in) disable iff (!rst_b_in)
    (!q.timeout[0] && q.mode[0][MODE_MAKER_BIT] && !q.mode[0][MODE_USER_BIT] &&
     (maker_y[0] == SAT_POS)) |=> (dac_code_out[0] == '1);
  endproperty
  a_saturate: assert property (p_saturate) else $error("saturated code wrong");
endmodule

// ### tb/cosc_coupler.sv
`timescale 1ns/1ps
module cosc_coupler
  import cosc_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Toward the block
  output logic [CHANNELS-1:0] valid_out,
  output logic [CHANNELS-1:0] ctrl_en_out,
  output logic [CHANNELS-1:0][CTRL_W-1:0] ctrl_out,
  output logic [CHANNELS-1:0][DATA_W-1:0] data_out
);
  initial begin
    valid_out = '0;
    ctrl_en_out = '0;
    ctrl_out = '0;
    data_out = '0;
  end
  // One word per channel, control byte only when mapped
  task automatic send(input int ch, input logic en, input logic [CTRL_W-1:0] c,
                      input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    valid_out[ch] <= 1'b1;
    ctrl_en_out[ch] <= en;
    ctrl_out[ch] <= en ? c : ~c;
    data_out[ch] <= d;
    @(posedge clock_in);
    valid_out[ch] <= 1'b0;
    ctrl_en_out[ch] <= 1'b0;
    // Released lines flip so a stale word is never taken for a new one
    ctrl_out[ch] <= ~c;
    data_out[ch] <= ~d;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import cosc_pkg::*;
();
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [CHANNELS-1:0] pd_valid, pd_ctrl_en, run;
  logic [CHANNELS-1:0][CTRL_W-1:0] pd_ctrl, pd_status;
  logic [CHANNELS-1:0][DATA_W-1:0] pd_data, pd_rdata;
  logic [CHANNELS-1:0][CODE_W-1:0] dac;
  logic irq;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  always #50 clock_in = ~clock_in;

  // Short tick and watchdog counts keep the run brief
  cosc_top #(.TICK_CYCLES_P(10), .WDT_TICKS_P(3)) u_cosc_top (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .pd_valid_in(pd_valid), .pd_ctrl_en_in(pd_ctrl_en),
    .pd_ctrl_in(pd_ctrl), .pd_data_in(pd_data), .pd_status_out(pd_status),
    .pd_rdata_out(pd_rdata), .dac_code_out(dac),
    .channel_run_indicator_out(run), .irq_out(irq));

  cosc_coupler u_cosc_coupler (
    .clock_in(clock_in), .valid_out(pd_valid), .ctrl_en_out(pd_ctrl_en),
    .ctrl_out(pd_ctrl), .data_out(pd_data));

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock_in);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock_in);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // Process word in, status one cycle later, code the cycle after
  task automatic pv(input int ch, input logic [DATA_W-1:0] d,
                    input logic [CODE_W-1:0] code);
    u_cosc_coupler.send(ch, 1'b0, 8'h00, d);
    @(posedge clock_in);
    #1 chk(16'(pd_status[ch]), 16'h0000);
    @(posedge clock_in);
    #1 chk(16'(dac[ch]), 16'(code));
  endtask

  task automatic t_reset();
    #1 chk(16'(run), 16'h0003);
    rd(7'(IDX_MGAIN), 16'h0100);
    rd({1'b1, IDX_UGAIN}, 16'h0100);
    rd(7'(IDX_MODE), 16'h0000);
    rd(7'h05, 16'h0000);
    chk(16'(irq), 16'h0000);
  endtask

  task automatic t_plain();
    pv(0, 16'h0000, 12'h000);
    pv(0, 16'h3FFF, 12'h7FF);
    pv(1, 16'h7FFF, 12'hFFF);
    pv(1, 16'hFFFF, 12'h000);
    pv(0, 16'h8000, 12'h000);
  endtask

  task automatic t_scale();
    wr(7'(IDX_MOFF), 16'h0100);
    wr(7'(IDX_MGAIN), 16'h0200);
    wr(7'(IDX_MODE), 16'h0001);
    pv(0, 16'h1000, 12'h420);
    pv(0, 16'h7000, 12'hFFF);
    pv(1, 16'h1000, 12'h200);
    wr(7'(IDX_MODE), 16'h0002);
    wr(7'(IDX_UOFF), 16'h0200);
    wr(7'(IDX_UGAIN), 16'h0080);
    pv(0, 16'h2000, 12'h240);
    wr(7'(IDX_MODE), 16'h0003);
    // Reversed order would give 0x2A0
    pv(0, 16'h1000, 12'h250);
  endtask

  task automatic t_ctrl();
    wr(7'(IDX_IRQ_STAT), 16'h000F);
    wr(7'(IDX_IRQ_MASK), 16'h0008);
    u_cosc_coupler.send(1, 1'b1, {2'b11, IDX_FALLBACK}, 16'h4000);
    @(posedge clock_in);
    #1 chk(16'(pd_status[1]), 16'h00E3);
    repeat (2) @(posedge clock_in);
    #1 chk(16'(irq), 16'h0001);
    u_cosc_coupler.send(1, 1'b1, {2'b10, IDX_FALLBACK}, 16'h1234);
    @(posedge clock_in);
    #1 chk(pd_rdata[1], 16'h4000);
    chk(16'(pd_status[1]), 16'h00A3);
    rd({1'b1, IDX_IRQ_MASK}, 16'h0000);
    wr(7'(IDX_IRQ_MASK), 16'h0000);
    repeat (2) @(posedge clock_in);
    #1 chk(16'(irq), 16'h0000);
    wr(7'(IDX_IRQ_MASK), 16'h0008);
    repeat (2) @(posedge clock_in);
    #1 chk(16'(irq), 16'h0001);
    wr(7'(IDX_IRQ_STAT), 16'h0008);
    repeat (2) @(posedge clock_in);
    #1 chk(16'(irq), 16'h0000);
  endtask

  // Four ticks of ten cycles stand for the long silence
  task automatic t_wdt();
    wr({1'b1, IDX_MODE}, 16'h0004);
    wr(7'(IDX_FALLBACK), 16'h2000);
    // Channel 0 takes its fallback mode through the control byte
    u_cosc_coupler.send(0, 1'b1, {2'b11, IDX_MODE}, 16'h0004);
    pv(1, 16'h7FFF, 12'hFFF);
    chk(16'(pd_status[0]), 16'h00E0);
    rd(7'(IDX_MODE), 16'h0004);
    repeat (25) @(posedge clock_in);
    #1 chk(16'(run[1]), 16'h0001);
    repeat (13) @(posedge clock_in);
    #1 chk(16'(run[1]), 16'h0000);
    chk(16'(dac[1]), 16'h0800);
    chk(16'(run[0]), 16'h0000);
    chk(16'(dac[0]), 16'h0400);
    wr(7'(IDX_MODE), 16'h0000);
    @(posedge clock_in);
    #1 chk(16'(dac[0]), 16'h0000);
    rd({1'b1, IDX_DIAG}, 16'h0001);
    pv(1, 16'h3FFF, 12'h7FF);
    chk(16'(run[1]), 16'h0001);
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (20) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_plain();
    t_scale();
    t_ctrl();
    t_wdt();
    conclude();
  end
endmodule
